// *** ame_pkg.sv ***
package ame_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CONFIG  = 4'h0;
   localparam logic [3:0] IDX_MAXLEN  = 4'h1;
   localparam logic [3:0] IDX_ADDR    = 4'h2;
   localparam logic [3:0] IDX_SEQUENCE_STATE = 4'h3;
   localparam logic [3:0] IDX_ACKLEN0 = 4'h4;
   localparam logic [3:0] IDX_ACKLEN1 = 4'h5;
   localparam logic [3:0] IDX_CRC_LO  = 4'h6;
   localparam logic [3:0] IDX_CRC_HI  = 4'h7;
   localparam logic [3:0] IDX_NTX     = 4'h8;
   localparam logic [3:0] IDX_NDUP    = 4'h9;
   localparam logic [3:0] IDX_NOK     = 4'hA;
   localparam logic [3:0] IDX_NBAD    = 4'hB;
   // entry_config bit positions
   localparam int CFG_PRI    = 0;
   localparam int CFG_SEC    = 1;
   localparam int CFG_KEEP   = 2;
   localparam int CFG_AA     = 3;
   localparam int CFG_VARIABLE_LENGTH_ENABLE = 4;
   localparam int CFG_SEQFF  = 5;
   localparam int CFG_FIXLEN = 6;
   localparam logic [7:0] CFG_MASK = 8'h7F;
   // sequence_state bit positions
   localparam int SQ_VALID = 0;
   localparam int SQ_SEQ   = 1;
   localparam int SQ_ACKSQ = 3;
   localparam int SQ_PAY   = 5;
   localparam int SQ_NEXT  = 6;
   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CRC  = 16'h0000;
   // packed configuration as seen by the link engine
   typedef struct packed {
      logic fixed_length_tx;
      logic seq_from_fifo;
      logic variable_length_enable;
      logic auto_ack_enable;
      logic keep_packet;
      logic secondary_sync_enable;
      logic primary_sync_enable;
   } ame_cfg_t;
   // events reported by the link engine, same clock
   typedef struct packed {
      logic        rx_task;
      logic        rx_done;
      logic        crc_ok;
      logic        is_ack;
      logic        tx_end;
      logic [1:0]  seq;
      logic [15:0] crc;
      logic        len_check;
      logic [7:0]  len;
      logic [1:0]  fifo_seq;
      logic        sync_secondary;
   } ame_ev_t;
endpackage

// *** ame_entry.sv ***
`timescale 1ns/1ps
module ame_entry
   import ame_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              ce,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire ame_pkg::ame_ev_t  ev,
   output ame_pkg::ame_cfg_t      cfg,
   output logic                   entry_enabled,
   output logic                   len_ok,
   output logic [1:0]             tx_seq,
   output logic                   free_packet,
   output logic                   ack_buf_sel,
   output logic [7:0]             ack_len
);
   import ame_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]  cfg_r, cfg_nxt;
   logic [6:0]  maxlen_r, maxlen_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic        valid_r, valid_nxt;
   logic [1:0]  seq_r, seq_nxt;
   logic [1:0]  ack_sequence_number_r, ack_sequence_number_nxt;
   logic        pay_r, pay_nxt;
   logic        next_r, next_nxt;
   logic [7:0]  len0_r, len0_nxt;
   logic [7:0]  len1_r, len1_nxt;
   logic [15:0] crc_r, crc_nxt;
   logic [7:0]  ntx_r, ntx_nxt;
   logic [7:0]  ndup_r, ndup_nxt;
   logic [7:0]  nok_r, nok_nxt;
   logic [7:0]  nbad_r, nbad_nxt;
   logic        en_r, lenok_r, free_r, bufsel_r;
   logic [1:0]  txseq_r;
   logic [7:0]  acklen_r;
   logic        wr_r, rd_r, hrdy_r;
   logic [3:0]  wix_r, rix_r;
   logic [31:0] hrdata_r;

   ////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [7:0] inc8(input logic [7:0] v, input logic up);
      inc8 = up ? 8'(v + 8'h01) : v;
   endfunction

   function automatic logic [1:0] inc2(input logic [1:0] v, input logic up);
      inc2 = up ? 2'(v + 2'h1) : v;
   endfunction

   function automatic logic length_fits(input logic [7:0] l, input logic [6:0] m,
                                        input logic var_en);
      length_fits = var_en ? (l <= {1'b0, m}) : (l == {1'b0, m});
   endfunction

   ////////////////////////////////////////////////////////////////////
   // bus address phase decode; only word offsets inside the map count
   wire        acc    = hsel & htrans[1] & hready;
   wire [3:0]  a_idx  = haddr[5:2];
   wire        a_map  = (haddr[31:6] == 26'h0) & (haddr[1:0] == 2'h0) & (a_idx <= IDX_NBAD);
   wire        wr_acc = acc & hwrite & a_map;
   wire        rd_acc = acc & ~hwrite;
   wire [7:0]  wbyte  = hwdata[7:0];

   // write strobes in the data phase
   wire we_cfg  = wr_r & (wix_r == IDX_CONFIG);
   wire we_max  = wr_r & (wix_r == IDX_MAXLEN);
   wire we_addr = wr_r & (wix_r == IDX_ADDR);
   wire we_len0 = wr_r & (wix_r == IDX_ACKLEN0);
   wire we_len1 = wr_r & (wix_r == IDX_ACKLEN1);

   ////////////////////////////////////////////////////////////////////
   // receive classification
   wire aa      = cfg_r[CFG_AA];
   wire rx_ev   = ev.rx_done & ev.rx_task;
   // a packet is new unless status is valid and both seq and crc repeat
   wire is_new  = ~valid_r | (ev.seq != seq_r) | (ev.crc != crc_r);
   wire rx_good = rx_ev & ev.crc_ok & is_new;
   wire rx_dup  = rx_ev & ev.crc_ok & ~is_new;
   wire crc_bad = ev.rx_done & ~ev.crc_ok;

   // a new packet confirms the payload carried by the previous ack
   wire entry_config    = rx_good & aa & pay_r;
   wire clr0    = entry_config & ~next_r & (len0_r != 8'h00);
   wire clr1    = entry_config & next_r & (len1_r != 8'h00);
   wire nbuf    = entry_config ? ~next_r : next_r;
   wire [7:0] nlen = nbuf ? len1_r : len0_r;

   // transmit side: ack for the current sequence, or plain end of tx
   wire tx_ack  = ev.rx_done & ~ev.rx_task & aa & ev.crc_ok & ev.is_ack
                  & (ev.seq == seq_r);
   wire tx_end  = ev.tx_end & ~ev.rx_task & ~aa;
   wire tx_fin  = tx_ack | tx_end;

   ////////////////////////////////////////////////////////////////////
   // configuration registers; bits above the field read zero
   assign cfg_nxt    = we_cfg  ? (wbyte & CFG_MASK) : cfg_r;
   assign maxlen_nxt = we_max  ? wbyte[6:0] : maxlen_r;
   assign addr_nxt   = we_addr ? wbyte : addr_r;

   // sequence state updates
   assign valid_nxt  = valid_r | rx_good;
   assign seq_nxt    = rx_good ? ev.seq : inc2(seq_r, tx_fin);
   assign ack_sequence_number_nxt = inc2(ack_sequence_number_r, rx_good & aa);
   assign pay_nxt    = (rx_good & aa) ? (nlen != 8'h00) : pay_r;
   assign next_nxt   = nbuf;
   assign crc_nxt    = rx_good ? ev.crc : crc_r;

   // ack lengths: firmware fills a free buffer, engine only clears it;
   // the two never overlap if firmware waits for zero, firmware wins if so
   assign len0_nxt = we_len0 ? wbyte : (clr0 ? 8'h00 : len0_r);
   assign len1_nxt = we_len1 ? wbyte : (clr1 ? 8'h00 : len1_r);

   // counters wrap by eight-bit arithmetic
   assign ntx_nxt  = inc8(ntx_r, entry_config | tx_fin);
   assign ndup_nxt = inc8(ndup_r, rx_dup);
   assign nok_nxt  = inc8(nok_r, rx_good | tx_ack);
   assign nbad_nxt = inc8(nbad_r, crc_bad);

   ////////////////////////////////////////////////////////////////////
   // read mux, one byte per word
   function automatic logic [7:0] rd_byte(input logic [3:0] i);
      unique case (i)
         IDX_CONFIG:  rd_byte = cfg_r;
         IDX_MAXLEN:  rd_byte = {1'b0, maxlen_r};
         IDX_ADDR:    rd_byte = addr_r;
         IDX_SEQUENCE_STATE: rd_byte = {1'b0, next_r, pay_r, ack_sequence_number_r, seq_r, valid_r};
         IDX_ACKLEN0: rd_byte = len0_r;
         IDX_ACKLEN1: rd_byte = len1_r;
         IDX_CRC_LO:  rd_byte = crc_r[7:0];
         IDX_CRC_HI:  rd_byte = crc_r[15:8];
         IDX_NTX:     rd_byte = ntx_r;
         IDX_NDUP:    rd_byte = ndup_r;
         IDX_NOK:     rd_byte = nok_r;
         IDX_NBAD:    rd_byte = nbad_r;
         default:     rd_byte = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // engine-facing outputs, registered
   wire en_nxt    = ev.sync_secondary ? cfg_r[CFG_SEC] : cfg_r[CFG_PRI];
   wire lenok_nxt = ev.len_check ? length_fits(ev.len, maxlen_r, cfg_r[CFG_VARIABLE_LENGTH_ENABLE])
                                 : lenok_r;
   wire [1:0] txs_nxt = cfg_r[CFG_SEQFF] ? ev.fifo_seq : seq_r;
   wire free_nxt  = tx_fin & ~cfg_r[CFG_KEEP];

   ////////////////////////////////////////////////////////////////////
   // entry state flops
   always_ff @(posedge clock) begin
      if (reset) begin
         cfg_r    <= RST_BYTE;
         maxlen_r <= 7'h00;
         addr_r   <= RST_BYTE;
         valid_r  <= 1'b0;
         seq_r    <= 2'h0;
         ack_sequence_number_r <= 2'h0;
         pay_r    <= 1'b0;
         next_r   <= 1'b0;
         len0_r   <= RST_BYTE;
         len1_r   <= RST_BYTE;
         crc_r    <= RST_CRC;
         ntx_r    <= RST_BYTE;
         ndup_r   <= RST_BYTE;
         nok_r    <= RST_BYTE;
         nbad_r   <= RST_BYTE;
      end else if (ce) begin
         cfg_r    <= cfg_nxt;
         maxlen_r <= maxlen_nxt;
         addr_r   <= addr_nxt;
         valid_r  <= valid_nxt;
         seq_r    <= seq_nxt;
         ack_sequence_number_r <= ack_sequence_number_nxt;
         pay_r    <= pay_nxt;
         next_r   <= next_nxt;
         len0_r   <= len0_nxt;
         len1_r   <= len1_nxt;
         crc_r    <= crc_nxt;
         ntx_r    <= ntx_nxt;
         ndup_r   <= ndup_nxt;
         nok_r    <= nok_nxt;
         nbad_r   <= nbad_nxt;
      end
   end

   // engine output flops
   always_ff @(posedge clock) begin
      if (reset) begin
         en_r     <= 1'b0;
         lenok_r  <= 1'b0;
         txseq_r  <= 2'h0;
         free_r   <= 1'b0;
         bufsel_r <= 1'b0;
         acklen_r <= RST_BYTE;
      end else if (ce) begin
         en_r     <= en_nxt;
         lenok_r  <= lenok_nxt;
         txseq_r  <= txs_nxt;
         free_r   <= free_nxt;
         bufsel_r <= next_nxt;
         acklen_r <= next_nxt ? len1_nxt : len0_nxt;
      end
   end

   // bus data phase; reads take one wait state so a write just before
   // a read of the same register is already visible
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_r     <= 1'b0;
         rd_r     <= 1'b0;
         wix_r    <= 4'h0;
         rix_r    <= 4'h0;
         hrdy_r   <= 1'b1;
         hrdata_r <= 32'h00000000;
      end else if (ce) begin
         wr_r <= wr_acc;
         wix_r <= a_idx;
         rd_r <= rd_acc;
         if (rd_acc) begin
            rix_r <= a_map ? a_idx : 4'hF;
            hrdy_r <= 1'b0;
         end else if (rd_r) begin
            // mux evaluated at the edge, so a register that changed under
            // an unchanged index is still seen with its current value
            hrdata_r <= {24'h000000, rd_byte(rix_r)};
            hrdy_r <= 1'b1;
         end
      end
   end

   assign hrdata        = hrdata_r;
   assign hreadyout     = hrdy_r;
   assign hresp         = 1'b0;
   assign cfg           = ame_cfg_t'(cfg_r[6:0]);
   assign entry_enabled = en_r;
   assign len_ok        = lenok_r;
   assign tx_seq        = txseq_r;
   assign free_packet   = free_r;
   assign ack_buf_sel   = bufsel_r;
   assign ack_len       = acklen_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_entry;
      @(posedge clock) disable iff (reset)
      ce & ~ev.sync_secondary |=> entry_enabled == $past(cfg_r[CFG_PRI]);
   endproperty
   a_entry: assert property (p_entry) else $error("entry enable wrong");

   property p_free;
      @(posedge clock) disable iff (reset)
      free_packet |-> $past(cfg_r[CFG_KEEP]) == 1'b0;
   endproperty
   a_free: assert property (p_free) else $error("kept packet freed");

   property p_fixlen;
      @(posedge clock) disable iff (reset)
      ce & ev.len_check & ~cfg_r[CFG_VARIABLE_LENGTH_ENABLE] & (ev.len != {1'b0, maxlen_r})
      |=> ~len_ok;
   endproperty
   a_fixlen: assert property (p_fixlen) else $error("fixed length accepted");

   property p_maxlen;
      @(posedge clock) disable iff (reset)
      ce & we_max |=> maxlen_r == $past(hwdata[6:0]);
   endproperty
   a_maxlen: assert property (p_maxlen) else $error("max length not stored");

   property p_valid;
      @(posedge clock) disable iff (reset)
      ce & rx_good |=> valid_r & (seq_r == $past(ev.seq)) & (crc_r == $past(ev.crc));
   endproperty
   a_valid: assert property (p_valid) else $error("good rx not recorded");

   property p_dup;
      @(posedge clock) disable iff (reset)
      ce & rx_dup |=> (ndup_r == 8'($past(ndup_r) + 8'h01)) & $stable(nok_r);
   endproperty
   a_dup: assert property (p_dup) else $error("duplicate miscounted");

   property p_bad;
      @(posedge clock) disable iff (reset)
      ce & crc_bad |=> (nbad_r == 8'($past(nbad_r) + 8'h01)) & $stable(crc_r);
   endproperty
   a_bad: assert property (p_bad) else $error("crc error miscounted");

   property p_clr;
      @(posedge clock) disable iff (reset)
      ce & entry_config & ~next_r & ~we_len0 |=> (len0_r == 8'h00) & next_r;
   endproperty
   a_clr: assert property (p_clr) else $error("ack buffer not freed");

   property p_txack;
      @(posedge clock) disable iff (reset)
      ce & tx_ack |=> (seq_r == 2'($past(seq_r) + 2'h1))
                      & (ntx_r == 8'($past(ntx_r) + 8'h01));
   endproperty
   a_txack: assert property (p_txack) else $error("tx ack not counted");

   property p_rdwait;
      @(posedge clock) disable iff (reset)
      ce & rd_acc |=> ~hreadyout;
   endproperty
   a_rdwait: assert property (p_rdwait) else $error("read wait state missing");

   property p_entry_sec;
      @(posedge clock) disable iff (reset)
      ce & ev.sync_secondary |=> entry_enabled == $past(cfg_r[CFG_SEC]);
   endproperty
   a_entry_sec: assert property (p_entry_sec) else $error("secondary enable wrong");

   property p_variable_length_enable;
      @(posedge clock) disable iff (reset)
      ce & ev.len_check & cfg_r[CFG_VARIABLE_LENGTH_ENABLE] & (ev.len > {1'b0, maxlen_r}) |=> ~len_ok;
   endproperty
   a_variable_length_enable: assert property (p_variable_length_enable) else $error("long packet accepted");

   property p_txfifo;
      @(posedge clock) disable iff (reset)
      ce & cfg_r[CFG_SEQFF] |=> tx_seq == $past(ev.fifo_seq);
   endproperty
   a_txfifo: assert property (p_txfifo) else $error("fifo sequence not used");

   property p_len0_hold;
      @(posedge clock) disable iff (reset)
      ce & ~we_len0 & (len0_r == 8'h00) |=> len0_r == 8'h00;
   endproperty
   a_len0_hold: assert property (p_len0_hold) else $error("free buffer 0 filled");

   property p_len1_hold;
      @(posedge clock) disable iff (reset)
      ce & ~we_len1 & (len1_r == 8'h00) |=> len1_r == 8'h00;
   endproperty
   a_len1_hold: assert property (p_len1_hold) else $error("free buffer 1 filled");

   property p_paydone;
      @(posedge clock) disable iff (reset)
      ce & entry_config |=> (ntx_r == 8'($past(ntx_r) + 8'h01)) & (next_r != $past(next_r));
   endproperty
   a_paydone: assert property (p_paydone) else $error("payload not confirmed");

   property p_ack_sequence_number;
      @(posedge clock) disable iff (reset)
      ce & rx_good & aa |=> ack_sequence_number_r == 2'($past(ack_sequence_number_r) + 2'h1);
   endproperty
   a_ack_sequence_number: assert property (p_ack_sequence_number) else $error("ack sequence stuck");
endmodule

// *** ame_engine_model.sv ***
`timescale 1ns/1ps
// link engine stand-in: drives event levels and one-cycle pulses on command
module ame_engine_model
   import ame_pkg::*;
(
   input  wire logic        clock,
   output ame_pkg::ame_ev_t ev
);
   import ame_pkg::*;

   // quiet start: no pulse is pending at time zero
   initial begin
      ev = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // task level and sync word kind, changed just after an edge
   task automatic level(input logic rx, input logic [1:0] fs, input logic sec);
      @(posedge clock);
      ev.rx_task        <= rx;
      ev.fifo_seq       <= fs;
      ev.sync_secondary <= sec;
   endtask

   // end of a received packet or ack with its qualifiers
   task automatic rx(input logic ok, input logic ack, input logic [1:0] s,
                     input logic [15:0] c);
      @(posedge clock);
      ev.rx_done <= 1'b1;
      ev.crc_ok  <= ok;
      ev.is_ack  <= ack;
      ev.seq     <= s;
      ev.crc     <= c;
      @(posedge clock);
      ev.rx_done <= 1'b0;
      // qualifiers other than is_ack stop holding: show the inverse, not a stale copy
      ev.crc_ok  <= ~ok;
      ev.seq     <= ~s;
      ev.crc     <= ~c;
   endtask

   // end of a transmission
   task automatic tx_done();
      @(posedge clock);
      ev.tx_end <= 1'b1;
      @(posedge clock);
      ev.tx_end <= 1'b0;
   endtask

   // length of a header just decoded
   task automatic len_chk(input logic [7:0] l);
      @(posedge clock);
      ev.len_check <= 1'b1;
      ev.len       <= l;
      @(posedge clock);
      ev.len_check <= 1'b0;
      ev.len       <= ~l;
   endtask
endmodule

// *** ame_entry_tb_top.sv ***
`timescale 1ns/1ps
module ame_entry_tb_top;
   import ame_pkg::*;
   logic             clock;
   logic             reset;
   logic             ce;
   logic             hsel;
   logic [31:0]      haddr;
   logic [1:0]       htrans;
   logic             hwrite;
   logic [2:0]       hsize;
   logic [31:0]      hwdata;
   logic [31:0]      hrdata;
   logic             hreadyout;
   logic             hresp;
   ame_ev_t          ev;
   ame_cfg_t         cfg;
   logic             entry_enabled;
   logic             len_ok;
   logic [1:0]       tx_seq;
   logic             free_packet;
   logic             ack_buf_sel;
   logic [7:0]       ack_len;
   int               miscompares = 0;
   int               compares = 0;
   logic [7:0]       ntx = 8'h00;
   logic [7:0]       ndup = 8'h00;
   logic [7:0]       nok = 8'h00;
   logic [7:0]       nbad = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // single slave, so its ready is the bus ready
   ame_entry i_ame_entry (.clock(clock), .reset(reset), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ev(ev), .cfg(cfg), .entry_enabled(entry_enabled), .len_ok(len_ok),
      .tx_seq(tx_seq), .free_packet(free_packet), .ack_buf_sel(ack_buf_sel),
      .ack_len(ack_len));
   ame_engine_model i_ame_engine_model (.clock(clock), .ev(ev));

   // 40 MHz clock
   initial clock = 1'b0;
   always #12.5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // one single word transfer; each phase held until hready is seen high
   task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] v,
                       output logic [31:0] d);
      @(posedge clock);
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {26'h0, i, 2'h0};
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
      htrans <= 2'h0;
      hwdata <= {24'h000000, v};
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
      d = hrdata;
   endtask

   task automatic wr(input logic [3:0] i, input logic [7:0] v);
      logic [31:0] d;
      xfer(1'b1, i, v, d);
   endtask

   task automatic rchk(input string n, input logic [3:0] i, input logic [7:0] e);
      logic [31:0] d;
      xfer(1'b0, i, 8'h00, d);
      chk(n, d, {24'h000000, e});
   endtask

   // length verdict shows one cycle after the check pulse
   task automatic lchk(input logic [7:0] l, input logic e);
      i_ame_engine_model.len_chk(l);
      @(posedge clock);
      chk("len_ok", 32'(len_ok), 32'(e));
   endtask

   // free pulse stands for exactly one cycle after the end of tx
   task automatic txchk(input logic e);
      i_ame_engine_model.tx_done();
      @(posedge clock);
      chk("free_packet", 32'(free_packet), 32'(e));
      @(posedge clock);
      chk("free_packet_end", 32'(free_packet), 32'h0);
   endtask

   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the sequence needs a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      report_and_stop();
   end

   // main sequence
   initial begin
      logic [31:0] d;
      logic [7:0]  cv;
      reset = 1'b1;
      ce = 1'b1;
      hsel = 1'b1;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      // index 12 is unmapped and must read zero
      for (int k = 0; k < 13; k++)
         rchk("reset_value", k[3:0], 8'h00);
      chk("hresp", 32'(hresp), 32'h0);
      wr(IDX_SEQUENCE_STATE, 8'hFF);
      rchk("sequence_state_ro", IDX_SEQUENCE_STATE, 8'h00);
      wr(IDX_CONFIG, 8'hFF);
      rchk("config", IDX_CONFIG, 8'h7F);
      chk("cfg", 32'(cfg), 32'h7F);
      wr(IDX_MAXLEN, 8'hFF);
      rchk("max_rx_length", IDX_MAXLEN, 8'h7F);
      wr(IDX_MAXLEN, 8'h0A);
      // entry chosen by the enable bit of the sync word kind
      for (int k = 0; k < 4; k++) begin
         cv = k[1] ? 8'h02 : 8'h01;
         wr(IDX_CONFIG, cv);
         i_ame_engine_model.level(1'b1, 2'h0, k[0]);
         repeat (2) @(posedge clock);
         chk("entry_enabled", 32'(entry_enabled), 32'(cv[k[0]]));
      end
      wr(IDX_CONFIG, 8'h00);
      lchk(8'h0A, 1'b1);
      lchk(8'h09, 1'b0);
      lchk(8'h0B, 1'b0);
      wr(IDX_CONFIG, 8'h10);
      lchk(8'h09, 1'b1);
      lchk(8'h0A, 1'b1);
      lchk(8'h0B, 1'b0);
      // receive without auto ack: new, duplicate, crc change, seq change, bad crc
      wr(IDX_CONFIG, 8'h01);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h1, 16'hABCD);
      rchk("sequence_state", IDX_SEQUENCE_STATE, 8'h03);
      rchk("crc_lo", IDX_CRC_LO, 8'hCD);
      rchk("crc_hi", IDX_CRC_HI, 8'hAB);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h1, 16'hABCD);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h1, 16'h1234);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h2, 16'h1234);
      i_ame_engine_model.rx(1'b0, 1'b0, 2'h3, 16'h9999);
      rchk("rx_duplicate_count", IDX_NDUP, 8'h01);
      rchk("rx_good_count", IDX_NOK, 8'h03);
      rchk("rx_bad_count", IDX_NBAD, 8'h01);
      rchk("sequence_state_seq", IDX_SEQUENCE_STATE, 8'h05);
      // transmit sequence source, then packet release
      i_ame_engine_model.level(1'b0, 2'h3, 1'b0);
      wr(IDX_CONFIG, 8'h00);
      chk("tx_seq_field", 32'(tx_seq), 32'h2);
      wr(IDX_CONFIG, 8'h20);
      // the source switch reaches tx_seq two cycles after the write lands
      repeat (2) @(posedge clock);
      chk("tx_seq_fifo", 32'(tx_seq), 32'h3);
      wr(IDX_CONFIG, 8'h00);
      txchk(1'b1);
      wr(IDX_CONFIG, 8'h04);
      txchk(1'b0);
      rchk("tx_done_count", IDX_NTX, 8'h02);
      // auto retransmission: ack with matching seq, wrong seq, wrap of seq
      // the two tx ends above moved the sequence from 2 through 3 to 0
      wr(IDX_CONFIG, 8'h08);
      i_ame_engine_model.rx(1'b1, 1'b1, 2'h0, 16'h0001);
      i_ame_engine_model.rx(1'b1, 1'b1, 2'h0, 16'h0002);
      rchk("tx_done_ack", IDX_NTX, 8'h03);
      for (int k = 1; k < 4; k++)
         i_ame_engine_model.rx(1'b1, 1'b1, k[1:0], 16'h0003);
      rchk("tx_done_ack2", IDX_NTX, 8'h06);
      chk("tx_seq_wrap", 32'(tx_seq), 32'h0);
      rchk("rx_good_ack", IDX_NOK, 8'h07);
      // auto ack with payload in buffer 0, written only while it reads zero
      i_ame_engine_model.level(1'b1, 2'h0, 1'b0);
      wr(IDX_CONFIG, 8'h09);
      rchk("ack0_free", IDX_ACKLEN0, 8'h00);
      wr(IDX_ACKLEN0, 8'h05);
      // registered ack length follows one cycle after the write lands
      @(posedge clock);
      chk("ack_buf_sel", 32'(ack_buf_sel), 32'h0);
      chk("ack_len", 32'(ack_len), 32'h5);
      xfer(1'b0, IDX_SEQUENCE_STATE, 8'h00, d);
      cv = {6'h00, d[4:3]} + 8'h01;
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h3, 16'h5555);
      rchk("ack0_kept", IDX_ACKLEN0, 8'h05);
      xfer(1'b0, IDX_SEQUENCE_STATE, 8'h00, d);
      chk("ack_seq", 32'(d[4:3]), 32'(cv[1:0]));
      chk("payload_flag", 32'(d[5]), 32'h1);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h0, 16'h6666);
      rchk("ack0_cleared", IDX_ACKLEN0, 8'h00);
      rchk("tx_done_payload", IDX_NTX, 8'h07);
      chk("ack_buf_next", 32'(ack_buf_sel), 32'h1);
      i_ame_engine_model.rx(1'b1, 1'b0, 2'h0, 16'h6666);
      rchk("ack1_untouched", IDX_ACKLEN1, 8'h00);
      rchk("rx_duplicate_aa", IDX_NDUP, 8'h02);
      // frozen by clock enable, then 256 bad packets wrap the counter
      ce <= 1'b0;
      i_ame_engine_model.rx(1'b0, 1'b0, 2'h1, 16'h7777);
      ce <= 1'b1;
      for (int k = 0; k < 256; k++)
         i_ame_engine_model.rx(1'b0, 1'b0, 2'h1, 16'h7777);
      rchk("rx_bad_wrap", IDX_NBAD, 8'h01);
      report_and_stop();
   end
endmodule
